// File: include/bmop_consts.svh
/*
 * register offsets, field positions, reset values and sizes of the
 * block-transfer mask, overlap and pitch engine.
 * assumes byte addresses on a 32-bit AHB-Lite register bus.
 */
`ifndef BMOP_CONSTS_SVH
`define BMOP_CONSTS_SVH

// register byte offsets
`define BMOP_CTRL_OFF      8'h00
`define BMOP_STAT_OFF      8'h04
`define BMOP_SRC_OFF       8'h08
`define BMOP_DST_OFF       8'h0c
`define BMOP_LEN_OFF       8'h10
`define BMOP_LINES_OFF     8'h14
`define BMOP_SPITCH_OFF    8'h18
`define BMOP_DPITCH_OFF    8'h1c
`define BMOP_FG_OFF        8'h20
`define BMOP_BG_OFF        8'h24
`define BMOP_SMASK_OFF     8'h28
`define BMOP_PMASK_LO_OFF  8'h2c
`define BMOP_PMASK_HI_OFF  8'h30

// control fields
`define BMOP_GO_BIT        0
`define BMOP_HREV_BIT      1
`define BMOP_VREV_BIT      2
`define BMOP_AUTO_BIT      3
`define BMOP_STR_BIT       4
`define BMOP_PTR_BIT       5
`define BMOP_DTM_LSB       6
`define BMOP_DTM_MSB       8

// status fields
`define BMOP_BUSY_BIT      0
`define BMOP_DONE_BIT      1

// reset value and sizes
`define BMOP_RST_WORD      32'h0000_0000
`define BMOP_FIFO_DEPTH    16
`define BMOP_PIX_BYTES     4

`endif

// File: include/bmop_pkg.sv
/*
 * types of the block-transfer mask, overlap and pitch engine.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package bmop_pkg;

    // engine sequencing states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_SRC   = 3'b010,
        ST_DST   = 3'b011,
        ST_PUSH  = 3'b100,
        ST_STEP  = 3'b101
    } bmop_state_t;

    // destination transparency selector codes
    typedef enum logic [2:0] {
        DT_OFF     = 3'b000,
        DT_DST_IN  = 3'b001,
        DT_DST_OUT = 3'b010,
        DT_SRC_IN  = 3'b011,
        DT_SRC_OUT = 3'b100
    } bmop_dtm_t;

    // width of the line-count and line-length fields
    typedef logic [15:0] bmop_cnt_t;

endpackage

// File: hdl/bmop_engine.sv
/*
 * block-transfer engine: pixel masking,
 * overlap-safe traversal corner,
 * pitch addressing and a write FIFO.
 * assumes one clock, sync active-high reset,
 * an AHB-Lite master and 32-bit pixels.
 */
// Functional notes
// - mono mask bit zero suppresses every byte of that destination pixel
// - only mono source or mono pattern may act as the bit mask
// - both operands transparent: pixel write enable is the AND of both
// - three-bit destination transparency selector picks colour-compare masking
// - compare each channel of destination or source against background..foreground
// - default traversal starts top-left, goes right then down
// - any of four corners selectable as start with matching directions
// - coordinate copy commands compare destination with source address and pick safe corner themselves
// - no overlapped pixel is written before its source is read
// - split rectangle needs only start, line bytes, pitch and line count
// - single line needs only start address, byte count and a line count of one
`timescale 1ns/1ps
`include "bmop_consts.svh"

module bmop_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = `BMOP_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // filling side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // draining side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out,
    // fill level
    output logic [$clog2(DEPTH):0] count_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wp_reg;
    logic [AW-1:0]    rp_reg;
    logic             push;
    logic             pop;

    // honest flags from the fill count
    assign in_ready_out  = (count_out != (AW+1)'(DEPTH));
    assign out_valid_out = (count_out != '0);
    assign out_data_out  = mem_reg[rp_reg];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    // storage
    always_ff @(posedge clk_in)
    begin
        if (push)
            mem_reg[wp_reg] <= in_data_in;
    end

    // pointers and count
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            wp_reg    <= '0;
            rp_reg    <= '0;
            count_out <= '0;
        end
        else
        begin
            if (push)
                wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
            if (pop)
                rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
            count_out <= count_out + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module bmop_engine #(
    parameter int FIFO_DEPTH = `BMOP_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    // ahb-lite register slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // memory read port
    output logic             rd_req_out,
    output logic [31:0]      rd_addr_out,
    input  wire logic        rd_ack_in,
    input  wire logic [31:0] rd_data_in,
    // memory write port
    output logic             wr_valid_out,
    output logic [31:0]      wr_addr_out,
    output logic [31:0]      wr_data_out,
    input  wire logic        wr_ready_in,
    // engine state
    output bmop_pkg::bmop_state_t state_out
);
    import bmop_pkg::*;

    logic [31:0] src_reg, dst_reg, spitch_reg, dpitch_reg;
    logic [31:0] fg_reg, bg_reg, smask_reg;
    logic [63:0] pmask_reg;
    bmop_cnt_t   len_reg, lines_reg;
    logic        hrev_reg, vrev_reg, auto_reg, str_reg, ptr_reg;
    logic [2:0]  dtm_reg;
    logic        done_reg;
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic [31:0] rd_mux;
    logic        acc, go, finish;
    logic        hr_reg, vr_reg;
    logic [13:0] x_reg, col;
    bmop_cnt_t   y_reg, row;
    logic [31:0] sline_reg, dline_reg, spix_reg, dpix_reg;
    logic [31:0] src_a, dst_a;
    logic [3:0]  s_in, d_in;
    logic        cmp_ok, s_bit, p_bit, wen, need_dst, last_px, vr_eff;
    logic        f_in_ready, f_out_valid, f_out_ready;
    logic [63:0] f_out_data;
    logic [$clog2(FIFO_DEPTH):0] f_count;
    logic [13:0] npix;

    assign npix     = len_reg[15:2];
    assign acc      = hsel_in & hready_in & htrans_in[1];
    assign go       = wr_pend_reg && (wr_addr_reg == `BMOP_CTRL_OFF)
                      && hwdata_in[`BMOP_GO_BIT] && (state_out == ST_IDLE);
    assign finish   = (state_out == ST_STEP) && last_px;
    assign last_px  = (x_reg == npix - 14'd1) && (y_reg == lines_reg - 16'd1);
    assign need_dst = (dtm_reg == DT_DST_IN) || (dtm_reg == DT_DST_OUT);

    // register read mux, unmapped offsets read zero
    always_comb
    begin
        case (haddr_in[7:0])
            `BMOP_CTRL_OFF:     rd_mux = {23'h0, dtm_reg, ptr_reg, str_reg, auto_reg,
                                          vrev_reg, hrev_reg, 1'b0};
            `BMOP_STAT_OFF:     rd_mux = {30'h0, done_reg,
                                          (state_out != ST_IDLE) | wr_valid_out
                                          | (f_count != '0)};
            `BMOP_SRC_OFF:      rd_mux = src_reg;
            `BMOP_DST_OFF:      rd_mux = dst_reg;
            `BMOP_LEN_OFF:      rd_mux = {16'h0, len_reg};
            `BMOP_LINES_OFF:    rd_mux = {16'h0, lines_reg};
            `BMOP_SPITCH_OFF:   rd_mux = spitch_reg;
            `BMOP_DPITCH_OFF:   rd_mux = dpitch_reg;
            `BMOP_FG_OFF:       rd_mux = fg_reg;
            `BMOP_BG_OFF:       rd_mux = bg_reg;
            `BMOP_SMASK_OFF:    rd_mux = smask_reg;
            `BMOP_PMASK_LO_OFF: rd_mux = pmask_reg[31:0];
            `BMOP_PMASK_HI_OFF: rd_mux = pmask_reg[63:32];
            default:            rd_mux = `BMOP_RST_WORD;
        endcase
    end

    // ahb address phase capture and zero-wait answer
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            wr_pend_reg   <= 1'b0;
            wr_addr_reg   <= 8'h00;
            hrdata_out    <= `BMOP_RST_WORD;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
        else
        begin
            wr_pend_reg <= acc & hwrite_in;
            if (acc)
                wr_addr_reg <= haddr_in[7:0];
            if (acc & ~hwrite_in)
                hrdata_out <= rd_mux;
        end
    end

    // parameter registers, frozen while the engine runs
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            {src_reg, dst_reg, spitch_reg, dpitch_reg} <= '0;
            {fg_reg, bg_reg, smask_reg, pmask_reg}     <= '0;
            {len_reg, lines_reg}                       <= '0;
            {hrev_reg, vrev_reg, auto_reg, str_reg, ptr_reg} <= '0;
            dtm_reg <= DT_OFF;
        end
        else if (wr_pend_reg && state_out == ST_IDLE)
        begin
            case (wr_addr_reg)
                `BMOP_CTRL_OFF:
                begin
                    hrev_reg <= hwdata_in[`BMOP_HREV_BIT];
                    vrev_reg <= hwdata_in[`BMOP_VREV_BIT];
                    auto_reg <= hwdata_in[`BMOP_AUTO_BIT];
                    str_reg  <= hwdata_in[`BMOP_STR_BIT];
                    ptr_reg  <= hwdata_in[`BMOP_PTR_BIT];
                    dtm_reg  <= hwdata_in[`BMOP_DTM_MSB:`BMOP_DTM_LSB];
                end
                `BMOP_SRC_OFF:      src_reg          <= hwdata_in;
                `BMOP_DST_OFF:      dst_reg          <= hwdata_in;
                `BMOP_LEN_OFF:      len_reg          <= hwdata_in[15:0];
                `BMOP_LINES_OFF:    lines_reg        <= hwdata_in[15:0];
                `BMOP_SPITCH_OFF:   spitch_reg       <= hwdata_in;
                `BMOP_DPITCH_OFF:   dpitch_reg       <= hwdata_in;
                `BMOP_FG_OFF:       fg_reg           <= hwdata_in;
                `BMOP_BG_OFF:       bg_reg           <= hwdata_in;
                `BMOP_SMASK_OFF:    smask_reg        <= hwdata_in;
                `BMOP_PMASK_LO_OFF: pmask_reg[31:0]  <= hwdata_in;
                `BMOP_PMASK_HI_OFF: pmask_reg[63:32] <= hwdata_in;
                default:            ;
            endcase
        end
    end

    // done flag, a new finish wins over a write-one clear
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
            done_reg <= 1'b0;
        else if (finish)
            done_reg <= 1'b1;
        else if (wr_pend_reg && wr_addr_reg == `BMOP_STAT_OFF
                 && hwdata_in[`BMOP_DONE_BIT])
            done_reg <= 1'b0;
    end

    // coordinate copy commands: reverse when destination lies below, at a higher address
    assign vr_eff = auto_reg ? (dst_reg > src_reg) : vrev_reg;

    // corner choice maps traversal index to column and row
    assign col   = hr_reg ? (npix - 14'd1 - x_reg) : x_reg;
    assign row   = vr_reg ? (lines_reg - 16'd1 - y_reg) : y_reg;
    // pixel address from line start and byte offset
    assign src_a = sline_reg + {16'h0, col, 2'b00};
    assign dst_a = dline_reg + {16'h0, col, 2'b00};

    for (genvar i = 0; i < `BMOP_PIX_BYTES; i++)
    begin : g_chan
        assign s_in[i] = (spix_reg[8*i +: 8] >= bg_reg[8*i +: 8])
                         && (spix_reg[8*i +: 8] <= fg_reg[8*i +: 8]);
        assign d_in[i] = (dpix_reg[8*i +: 8] >= bg_reg[8*i +: 8])
                         && (dpix_reg[8*i +: 8] <= fg_reg[8*i +: 8]);
    end

    // selector picks which compare gates the write
    always_comb
    begin
        case (dtm_reg)
            DT_DST_IN:  cmp_ok = &d_in;
            DT_DST_OUT: cmp_ok = ~&d_in;
            DT_SRC_IN:  cmp_ok = &s_in;
            DT_SRC_OUT: cmp_ok = ~&s_in;
            default:    cmp_ok = 1'b1;
        endcase
    end

    // mono mask bits, source by column, pattern by 8x8 tile
    assign s_bit = str_reg ? smask_reg[col[4:0]] : 1'b1;
    assign p_bit = ptr_reg ? pmask_reg[{row[2:0], col[2:0]}] : 1'b1;
    // both transparent: AND of the two mask bits
    assign wen   = s_bit & p_bit & cmp_ok;

    // sequencer, counters, line bases and read port
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            state_out   <= ST_IDLE;
            {hr_reg, vr_reg} <= 2'b00;
            {x_reg, y_reg}   <= '0;
            {sline_reg, dline_reg, spix_reg, dpix_reg} <= '0;
            rd_req_out  <= 1'b0;
            rd_addr_out <= 32'h0000_0000;
        end
        else
        begin
            case (state_out)
                ST_IDLE:
                    if (go)
                        state_out <= ST_SETUP;
                ST_SETUP:
                begin
                    hr_reg <= auto_reg ? (dst_reg > src_reg) : hrev_reg;
                    vr_reg <= vr_eff;
                    x_reg  <= '0;
                    y_reg  <= '0;
                    // first line at bottom when going upward
                    sline_reg <= src_reg + (vr_eff ? 32'((lines_reg - 16'd1)
                                 * spitch_reg) : 32'h0);
                    dline_reg <= dst_reg + (vr_eff ? 32'((lines_reg - 16'd1)
                                 * dpitch_reg) : 32'h0);
                    state_out <= (npix == '0 || lines_reg == '0) ? ST_IDLE : ST_SRC;
                end
                ST_SRC:
                    // source read completes before its write is queued
                    if (!rd_req_out)
                    begin
                        rd_req_out  <= 1'b1;
                        rd_addr_out <= src_a;
                    end
                    else if (rd_ack_in)
                    begin
                        rd_req_out <= 1'b0;
                        spix_reg   <= rd_data_in;
                        state_out  <= need_dst ? ST_DST : ST_PUSH;
                    end
                ST_DST:
                    if (!rd_req_out)
                    begin
                        rd_req_out  <= 1'b1;
                        rd_addr_out <= dst_a;
                    end
                    else if (rd_ack_in)
                    begin
                        rd_req_out <= 1'b0;
                        dpix_reg   <= rd_data_in;
                        state_out  <= ST_PUSH;
                    end
                ST_PUSH:
                    if (!wen || f_in_ready)
                        state_out <= ST_STEP;
                ST_STEP:
                begin
                    if (x_reg == npix - 14'd1)
                    begin
                        x_reg <= '0;
                        y_reg <= y_reg + 16'd1;
                        // next line start moves by signed pitch
                        sline_reg <= vr_reg ? sline_reg - spitch_reg
                                            : sline_reg + spitch_reg;
                        dline_reg <= vr_reg ? dline_reg - dpitch_reg
                                            : dline_reg + dpitch_reg;
                    end
                    else
                        x_reg <= x_reg + 14'd1;
                    state_out <= last_px ? ST_IDLE : ST_SRC;
                end
                default:
                    state_out <= ST_IDLE;
            endcase
        end
    end

    // write buffer; a full FIFO holds the sequencer in push
    bmop_fifo #(
        .WIDTH (64),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (core_clk_in),
        .rst_in        (sys_rst_in),
        // unmasked pixels write the whole word
        .in_valid_in   ((state_out == ST_PUSH) && wen),
        .in_ready_out  (f_in_ready),
        .in_data_in    ({dst_a, spix_reg}),
        .out_valid_out (f_out_valid),
        .out_ready_in  (f_out_ready),
        .out_data_out  (f_out_data),
        .count_out     (f_count)
    );

    // registered memory write stage, stalls on wr_ready_in
    assign f_out_ready = ~wr_valid_out | wr_ready_in;
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            wr_valid_out <= 1'b0;
            wr_addr_out  <= 32'h0;
            wr_data_out  <= 32'h0;
        end
        else if (f_out_ready)
        begin
            wr_valid_out <= f_out_valid;
            wr_addr_out  <= f_out_data[63:32];
            wr_data_out  <= f_out_data[31:0];
        end
    end
endmodule

// File: verif/bmop_checker.sv
/*
 * assertions on the engine's ports, bound into it.
 * assumes one clock and synchronous reset.
 */
`timescale 1ns/1ps
module bmop_checker (
    // clock, reset, register bus
    input wire logic        core_clk_in,
    input wire logic        sys_rst_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    // memory ports and state
    input wire logic        rd_req_out,
    input wire logic [31:0] rd_addr_out,
    input wire logic        rd_ack_in,
    input wire logic        wr_valid_out,
    input wire logic [31:0] wr_addr_out,
    input wire logic [31:0] wr_data_out,
    input wire logic        wr_ready_in,
    input wire logic [2:0]  state_out
);
    import bmop_pkg::*;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    // bus and memory handshake relations
    property p_no_wait; hreadyout_out && !hresp_out; endproperty
    property p_rd_hold; rd_req_out && !rd_ack_in |=> rd_req_out && $stable(rd_addr_out); endproperty
    property p_rd_drop; rd_req_out && rd_ack_in |=> !rd_req_out; endproperty
    property p_wr_hold;
        wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable(wr_addr_out)
            && $stable(wr_data_out);
    endproperty
    property p_idle_quiet; state_out == ST_IDLE |-> !rd_req_out; endproperty
    property p_word_addr;
        (rd_req_out |-> rd_addr_out[1:0] == 2'h0) and (wr_valid_out |-> wr_addr_out[1:0] == 2'h0);
    endproperty
    property p_unmapped;
        hsel_in && htrans_in[1] && !hwrite_in && haddr_in[7:0] == 8'h40 |=> hrdata_out == 32'h0;
    endproperty
    property p_go;
        state_out == ST_IDLE && hsel_in && htrans_in[1] && hwrite_in && haddr_in[7:0] == 8'h00
            ##1 hwdata_in[0] |=> state_out != ST_IDLE;
    endproperty

    a_no_wait: assert property (p_no_wait) else $error("bus wait");
    a_rd_hold: assert property (p_rd_hold) else $error("rd dropped");
    a_rd_drop: assert property (p_rd_drop) else $error("rd kept");
    a_wr_hold: assert property (p_wr_hold) else $error("wr changed");
    a_idle_quiet: assert property (p_idle_quiet) else $error("idle read");
    a_word_addr: assert property (p_word_addr) else $error("unaligned");
    a_unmapped: assert property (p_unmapped) else $error("unmapped");
    a_go: assert property (p_go) else $error("no start");

    // main scenarios reached
    c_read: cover property (rd_req_out && rd_ack_in);
    c_stall: cover property ((wr_valid_out && !wr_ready_in) [*4]);
    c_dst: cover property (state_out == ST_DST);
endmodule

bind bmop_engine bmop_checker u_chk (.*);

// File: verif/bmop_mem_model.sv
/*
 * 256-word frame buffer model.
 * assumes byte addresses below 0x400; the bench preloads and reads mem.
 */
`timescale 1ns/1ps
module bmop_mem_model (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // read port
    input  wire logic        rd_req_in,
    input  wire logic [31:0] rd_addr_in,
    output logic             rd_ack_out,
    output logic [31:0]      rd_data_out,
    // write port
    input  wire logic        wr_valid_in,
    input  wire logic [31:0] wr_addr_in,
    input  wire logic [31:0] wr_data_in,
    output logic             wr_ready_out,
    // behaviour controls
    input  wire logic        slow_in,
    input  wire logic        stall_in
);
    logic [31:0] mem [0:255];
    logic [1:0]  wait_reg;

    // read answer after 0 or 2 waits; data toggles outside the ack
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            rd_ack_out <= 1'b0;
            wait_reg <= 2'h0;
            rd_data_out <= 32'h5a5a_a5a5;
        end
        else if (rd_req_in && !rd_ack_out && wait_reg >= {slow_in, 1'b0})
        begin
            rd_ack_out <= 1'b1;
            rd_data_out <= mem[rd_addr_in[9:2]];
            wait_reg <= 2'h0;
        end
        else
        begin
            rd_ack_out <= 1'b0;
            rd_data_out <= ~rd_data_out;
            wait_reg <= (rd_req_in && !rd_ack_out) ? wait_reg + 2'h1 : 2'h0;
        end
    end

    // write acceptance, stalled on command
    assign wr_ready_out = !stall_in;
    always @(posedge clk_in)
    begin
        if (wr_valid_in && wr_ready_out)
            mem[wr_addr_in[9:2]] <= wr_data_in;
    end
endmodule

// File: verif/test_blit_mask_overlap_pitch.sv
/*
 * self-checking bench for the block-transfer engine.
 * assumes the memory model and the bound checker alongside.
 */
`timescale 1ns/1ps
module test_blit_mask_overlap_pitch;
    import bmop_pkg::*;
    logic clk, rst, hready, hresp, rd_req, rd_ack, wr_valid, wr_ready;
    bit          hwrite, slow, stall;
    bit   [1:0]  htrans;
    bit   [31:0] haddr, hwdata;
    logic [31:0] hrdata, rd_addr, rd_data, wr_addr, wr_data, first_wr;
    logic [31:0] snap [0:255];
    logic [31:0] expv [0:255];
    bit   [31:0] smask_v, fg_v, bg_v;
    bit   [63:0] pmask_v;
    bmop_state_t state;
    bit          got_first;
    int          n_mismatch, samples_checked;

    bmop_engine dut (.core_clk_in(clk), .sys_rst_in(rst), .hsel_in(1'b1), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .rd_req_out(rd_req), .rd_addr_out(rd_addr), .rd_ack_in(rd_ack), .rd_data_in(rd_data),
        .wr_valid_out(wr_valid), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
        .wr_ready_in(wr_ready), .state_out(state));
    bmop_mem_model u_mem (.clk_in(clk), .rst_in(rst), .rd_req_in(rd_req), .rd_addr_in(rd_addr),
        .rd_ack_out(rd_ack), .rd_data_out(rd_data), .wr_valid_in(wr_valid), .wr_addr_in(wr_addr),
        .wr_data_in(wr_data), .wr_ready_out(wr_ready), .slow_in(slow), .stall_in(stall));

    // clock of 40 ns
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // first accepted write of each transfer
    always @(posedge clk)
    begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1 && !got_first)
        begin
            first_wr = wr_addr;
            got_first = 1'b1;
        end
    end

    task test_done;
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one single transfer, entered just after a rising edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    function automatic logic inr(input logic [31:0] x);
        inr = 1'b1;
        for (int k = 0; k < 4; k++)
            if (x[8*k+:8] < bg_v[8*k+:8] || x[8*k+:8] > fg_v[8*k+:8]) inr = 1'b0;
    endfunction

    // preload words in and out of the colour range
    task fill;
        for (int i = 0; i < 256; i++)
            u_mem.mem[i] = ((i * 7) % 5 < 2) ? 32'h5060_7040 | (i & 31) : 32'h9000_0000 | i;
    endtask

    // program, run and judge one transfer against the predicted memory
    task blit(input logic [8:0] ctrl, input logic [31:0] src, dst, input logic [15:0] len, lines,
              input logic [31:0] sp, dp);
        logic [31:0] q, s, d;
        logic en, hr, vr;
        int i;
        snap = u_mem.mem;
        expv = snap;
        for (int r = 0; r < lines; r++)
            for (int c = 0; c < len / 4; c++)
            begin
                s = src + r * sp + c * 4;
                d = dst + r * dp + c * 4;
                en = (!ctrl[4] || smask_v[c % 32]) && (!ctrl[5] || pmask_v[(r % 8) * 8 + c % 8]);
                case (ctrl[8:6])
                    3'h1: en &= inr(snap[d[9:2]]);
                    3'h2: en &= !inr(snap[d[9:2]]);
                    3'h3: en &= inr(snap[s[9:2]]);
                    3'h4: en &= !inr(snap[s[9:2]]);
                    default: ;
                endcase
                if (en) expv[d[9:2]] = snap[s[9:2]];
            end
        {vr, hr} = ctrl[3] ? {2{dst > src}} : ctrl[2:1];
        wr(8'h08, src);
        wr(8'h0c, dst);
        wr(8'h10, {16'h0, len});
        wr(8'h14, {16'h0, lines});
        wr(8'h18, sp);
        wr(8'h1c, dp);
        got_first = 1'b0;
        wr(8'h00, {23'h0, ctrl} | 32'h1);
        q = 32'h1;
        for (i = 0; i < 600 && q[0] !== 1'b0; i++) bus(1'b0, 8'h04, 32'h0, q);
        chk(q, 32'h2);
        wr(8'h04, 32'h2);
        rd_chk(8'h04, 32'h0);
        for (i = 0; i < 256; i++) chk(u_mem.mem[i], expv[i]);
        d = dst + (vr ? (lines - 1) * dp : 0) + (hr ? len - 4 : 0);
        if (ctrl[8:4] == 5'h0) chk(first_wr, d);
    endtask

    task t_regs;
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h0);
        wr(8'h08, 32'h0000_0124);
        rd_chk(8'h08, 32'h0000_0124);
        wr(8'h40, 32'hffff_ffff);
        rd_chk(8'h40, 32'h0);
    endtask

    // writes stalled with slow reads: queue fills and engine waits
    task t_fifo;
        slow <= 1'b1;
        stall <= 1'b1;
        fork
            begin
                repeat (300) @(posedge clk);
                chk({29'h0, state}, {29'h0, ST_PUSH});
                stall <= 1'b0;
            end
        join_none
        blit(9'h0, 32'h000, 32'h200, 16'd24, 16'd4, 32'h40, 32'h40);
        slow <= 1'b0;
    endtask

    task t_single;
        blit(9'h0, 32'h100, 32'h300, 16'd16, 16'd1, 32'h0, 32'h0);
    endtask

    task t_overlap;
        blit(9'h008, 32'h000, 32'h008, 16'd16, 16'd3, 32'h40, 32'h40);
        blit(9'h008, 32'h048, 32'h000, 16'd16, 16'd3, 32'h40, 32'h40);
        blit(9'h006, 32'h000, 32'h008, 16'd16, 16'd3, 32'h40, 32'h40);
    endtask

    task t_corners;
        for (int k = 0; k < 4; k++)
            blit(9'(k * 2), 32'h100, 32'h300, 16'd12, 16'd3, 32'h20, 32'h20);
    endtask

    task t_mask;
        smask_v = 32'h0000_00a5;
        pmask_v = 64'h3c00_00ff_0000_0f0f;
        wr(8'h28, smask_v);
        wr(8'h2c, pmask_v[31:0]);
        wr(8'h30, pmask_v[63:32]);
        blit(9'h010, 32'h000, 32'h300, 16'd32, 16'd3, 32'h40, 32'h40);
        blit(9'h020, 32'h000, 32'h200, 16'd32, 16'd8, 32'h20, 32'h20);
        blit(9'h030, 32'h000, 32'h200, 16'd32, 16'd8, 32'h20, 32'h20);
    endtask

    task t_dtm;
        fg_v = 32'h8080_8080;
        bg_v = 32'h4040_4040;
        wr(8'h20, fg_v);
        wr(8'h24, bg_v);
        for (int m = 0; m < 8; m++)
        begin
            fill;
            blit(9'(m * 64), 32'h000, 32'h300, 16'd20, 16'd3, 32'h40, 32'h40);
        end
    endtask

    // watchdog against a hung engine or bus
    initial
    begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        test_done;
    end

    // reset, then the scenarios
    initial
    begin
        rst = 1'b1;
        fill;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_fifo;
        t_single;
        t_overlap;
        t_corners;
        t_mask;
        t_dtm;
        test_done;
    end
endmodule
